/* File: hdl/twe_target.sv */
// Two-wire serial memory target: link capture, protocol engine, page write and array
//
// Overview of operation
// - Command and write bits are taken from the data line on serial clock rise.
// - Read data and acknowledge change only after the serial clock falls.
// - The data line is only pulled low or released, never driven high.
// - Respond only when received select bits equal the three chip-select inputs.
// - Unconnected chip-select and write-protect inputs count as low.
// - Write-protect high blocks every array write and keeps contents unchanged.
// - Write-protect low lets byte and page writes program normally.
// - Array holds 128 or 256 bytes depending on the density variant.
// - Page writes of up to eight bytes, partial pages also accepted.
// - After a write transfer, programming is self-timed and lasts 5 ms plus eight reference cycles.
// - Random address reads and sequential reads within one transfer are supported.
// - Serial clock runs at up to 100 kHz, 400 kHz or 1 MHz.
`timescale 1ns/10ps
`default_nettype none
module twe_target #(
   parameter bit large_array = 1'b1,
   parameter int unsigned write_cycles = twe_pkg::TWE_WRITE_CYCLES
) (
   // Reference clock and reset
   input wire logic ref_clk,
   input wire logic rst_n,
   // Serial link
   input wire logic scl_clk,
   input wire logic sda_i,
   output logic sda_o,
   output logic sda_oe,
   // Strapping pins
   input wire twe_pkg::twe_straps_t straps,
   // Status
   output logic write_busy
);
   import twe_pkg::*;

   typedef struct packed {
      twe_state_t st;
      logic [3:0] cnt;
      logic [7:0] sh;
      logic [7:0] ptr;
      logic [7:0] rd;
      logic rw;
      logic drive;
      logic scl_q;
      logic sda_q;
      logic tgl_q;
      logic [TWE_PAGE_BYTES-1:0][7:0] page;
      logic [TWE_PAGE_BYTES-1:0] page_valid;
      logic commit;
      logic discard;
      logic prog;
      logic [2:0] prog_idx;
      logic [4:0] page_base;
      logic busy;
      logic [TWE_TIMER_W-1:0] timer;
      logic sda_o;
   } twe_target_st_t;

   twe_target_st_t r;
   twe_target_st_t next_r;

   // Link-domain state
   logic link_bit;
   logic link_tgl;

   // Array storage
   logic [7:0] mem [TWE_DEPTH_LARGE];
   logic mem_we;
   logic [7:0] mem_waddr;
   logic [7:0] mem_rd;

   // Synchronised pins
   logic [TWE_SYNC_W-1:0] sync_q;
   logic s_scl;
   logic s_sda;
   logic s_tgl;
   logic [2:0] s_cs;
   logic s_wp;

   // Buffer handshake
   logic buf_in_valid;
   logic buf_in_ready;
   twe_wbyte_t buf_in_data;
   logic buf_out_valid;
   logic buf_out_ready;
   twe_wbyte_t buf_out_data;

   // Comb helpers
   logic start_ev;
   logic stop_ev;
   logic bit_ev;
   logic [7:0] rx_byte;
   logic sel_match;

   // Folds an address onto the array size of this variant
   function automatic logic [7:0] twe_wrap(input logic [7:0] a);
      twe_wrap = large_array ? a : {1'b0, a[6:0]};
   endfunction

   // Next address inside the same eight-byte page
   function automatic logic [7:0] twe_page_next(input logic [7:0] a);
      twe_page_next = twe_wrap({a[7:3], a[2:0] + 3'h1});
   endfunction

   // Link domain: sample on rise and flag each bit by a toggle
   always_ff @(posedge scl_clk or negedge rst_n) begin
      if (!rst_n) begin
         link_bit <= 1'b0;
         link_tgl <= 1'b0;
      end else begin
         link_bit <= sda_i;
         link_tgl <= ~link_tgl;
      end
   end

   // Drive request is settled long before the fall, since it is set just after the rise
   always_ff @(negedge scl_clk or negedge rst_n) begin
      if (!rst_n) begin
         sda_oe <= 1'b0;
      end else begin
         sda_oe <= r.drive;
      end
   end

   // Pins into the reference domain; a 100 MHz sample rate leaves many cycles per bit at 1 MHz
   twe_sync2 #(
      .W(TWE_SYNC_W)
   ) u_sync (
      .clk(ref_clk),
      .rst_n(rst_n),
      .d({scl_clk, sda_i, link_tgl, straps.chip_select, straps.write_protect}),
      .q(sync_q)
   );

   // Floating straps are pulled low on the board, so a low level means unconnected
   assign s_scl = sync_q[6];
   assign s_sda = sync_q[5];
   assign s_tgl = sync_q[4];
   assign s_cs = sync_q[3:1];
   assign s_wp = sync_q[0];

   twe_buf2 u_buf (
      .clk(ref_clk),
      .rst_n(rst_n),
      .in_valid(buf_in_valid),
      .in_ready(buf_in_ready),
      .in_data(buf_in_data),
      .out_valid(buf_out_valid),
      .out_ready(buf_out_ready),
      .out_data(buf_out_data)
   );

   // Idle bus has a high clock, so a data edge while it is high frames a transfer
   assign start_ev = s_scl & r.scl_q & r.sda_q & ~s_sda;
   assign stop_ev = s_scl & r.scl_q & ~r.sda_q & s_sda;
   assign bit_ev = s_tgl ^ r.tgl_q;
   assign rx_byte = {r.sh[6:0], link_bit};
   assign sel_match = (rx_byte[7:4] == TWE_TYPE_CODE) && (rx_byte[3:1] == s_cs);
   assign buf_out_ready = ~r.prog & ~r.commit;
   assign mem_rd = mem[r.ptr];
   assign mem_waddr = twe_wrap({r.page_base, r.prog_idx});
   assign mem_we = r.prog & r.page_valid[r.prog_idx];

   always_comb begin
      next_r = r;
      next_r.scl_q = s_scl;
      next_r.sda_q = s_sda;
      next_r.tgl_q = s_tgl;
      next_r.sda_o = 1'b0;
      buf_in_valid = 1'b0;
      buf_in_data = '{addr: r.ptr, data: rx_byte};

      // Drained bytes land in the page latch, or are dropped after an aborted write
      if (buf_out_valid & buf_out_ready) begin
         if (!r.discard) begin
            next_r.page[buf_out_data.addr[2:0]] = buf_out_data.data;
            next_r.page_valid[buf_out_data.addr[2:0]] = 1'b1;
            next_r.page_base = buf_out_data.addr[7:3];
         end
      end
      if (r.discard & ~buf_out_valid) begin
         next_r.discard = 1'b0;
      end

      if (start_ev) begin
         // A restart abandons any unfinished page
         if (r.st == TWE_WDATA) begin
            next_r.page_valid = '0;
            next_r.discard = 1'b1;
         end
         next_r.st = TWE_DEV;
         next_r.cnt = 4'h0;
         next_r.drive = 1'b0;
      end else if (stop_ev) begin
         if ((r.st == TWE_WDATA) && !r.discard) begin
            next_r.commit = 1'b1;
         end
         next_r.st = TWE_IDLE;
         next_r.drive = 1'b0;
      end else if (bit_ev && (r.st != TWE_IDLE) && (r.st != TWE_IGNORE)) begin
         if (r.cnt == TWE_ACK_SLOT) begin
            // Ninth clock: acknowledge slot has been sampled
            next_r.cnt = 4'h0;
            next_r.drive = 1'b0;
            case (r.st)
               TWE_DEV: begin
                  if (r.rw) begin
                     next_r.st = TWE_READ;
                     next_r.rd = mem_rd;
                     next_r.drive = ~mem_rd[7];
                  end else begin
                     next_r.st = TWE_WADDR;
                  end
               end
               TWE_READ: begin
                  // Controller acknowledge continues the sequential read
                  if (!link_bit) begin
                     next_r.rd = mem_rd;
                     next_r.drive = ~mem_rd[7];
                  end else begin
                     next_r.st = TWE_IGNORE;
                  end
               end
               default: next_r.st = r.st;
            endcase
         end else if (r.st == TWE_READ) begin
            next_r.cnt = r.cnt + 4'h1;
            if (r.cnt == 4'h7) begin
               next_r.drive = 1'b0;
               next_r.ptr = twe_wrap(r.ptr + 8'h01);
            end else begin
               next_r.drive = ~r.rd[3'h6 - r.cnt[2:0]];
            end
         end else begin
            next_r.sh = rx_byte;
            next_r.cnt = r.cnt + 4'h1;
            if (r.cnt == 4'h7) begin
               case (r.st)
                  TWE_DEV: begin
                     // Silent while programming so the controller can poll
                     if (sel_match && !r.busy && !r.commit && !r.prog) begin
                        next_r.drive = 1'b1;
                        next_r.rw = rx_byte[0];
                     end else begin
                        next_r.st = TWE_IGNORE;
                     end
                  end
                  TWE_WADDR: begin
                     next_r.ptr = twe_wrap(rx_byte);
                     next_r.page_valid = '0;
                     next_r.drive = 1'b1;
                  end
                  TWE_WDATA: begin
                     // A full buffer refuses the byte by leaving it unacknowledged
                     buf_in_valid = 1'b1;
                     if (buf_in_ready) begin
                        next_r.drive = 1'b1;
                        next_r.ptr = twe_page_next(r.ptr);
                     end
                  end
                  default: next_r.drive = 1'b0;
               endcase
            end
         end
         if ((r.cnt == TWE_ACK_SLOT) && (r.st == TWE_WADDR)) begin
            next_r.st = TWE_WDATA;
         end
      end

      // Commit once every received byte has reached the page latch
      if (r.commit && !buf_out_valid) begin
         next_r.commit = 1'b0;
         if ((r.page_valid != '0) && !s_wp) begin
            next_r.prog = 1'b1;
            next_r.prog_idx = 3'h0;
            next_r.busy = 1'b1;
            next_r.timer = '0;
         end else begin
            next_r.page_valid = '0;
         end
      end

      // One page entry per cycle, then the self-timed wait
      if (r.prog) begin
         next_r.prog_idx = r.prog_idx + 3'h1;
         if (r.prog_idx == TWE_PAGE_LAST) begin
            next_r.prog = 1'b0;
            next_r.page_valid = '0;
         end
      end else if (r.busy) begin
         if (r.timer == TWE_TIMER_W'(write_cycles - 1)) begin
            next_r.busy = 1'b0;
         end else begin
            next_r.timer = r.timer + TWE_TIMER_W'(1);
         end
      end
   end

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         r <= '{st: TWE_IDLE, scl_q: 1'b1, sda_q: 1'b1, default: '0};
      end else begin
         r <= next_r;
      end
   end

   // Array has no reset; only the page engine writes it
   always_ff @(posedge ref_clk) begin
      if (mem_we) begin
         mem[mem_waddr] <= r.page[r.prog_idx];
      end
   end

   assign sda_o = r.sda_o;
   assign write_busy = r.busy;
endmodule
`default_nettype wire

/* File: hdl/twe_pkg.sv */
// Shared constants and types for the two-wire memory target
package twe_pkg;
   // Device type nibble expected in bits 7:4 of the select byte
   localparam logic [3:0] TWE_TYPE_CODE = 4'ha;
   localparam int TWE_DEPTH_LARGE = 256;
   localparam int TWE_DEPTH_SMALL = 128;
   localparam int TWE_PAGE_BYTES = 8;
   localparam logic [3:0] TWE_ACK_SLOT = 4'h8;
   localparam logic [2:0] TWE_PAGE_LAST = 3'h7;
   // Self-timed programming time and reference clock period
   localparam int unsigned TWE_WRITE_TIME_US = 5000;
   localparam int unsigned TWE_CLK_PERIOD_NS = 10;
   localparam int unsigned TWE_WRITE_CYCLES = TWE_WRITE_TIME_US * 1000 / TWE_CLK_PERIOD_NS;
   localparam int TWE_TIMER_W = 20;
   // Sync vector layout: scl, sda, bit toggle, chip select (3), write protect
   localparam int TWE_SYNC_W = 7;

   typedef struct packed {
      logic [2:0] chip_select;
      logic write_protect;
   } twe_straps_t;

   typedef struct packed {
      logic [7:0] addr;
      logic [7:0] data;
   } twe_wbyte_t;

   typedef enum logic [2:0] {
      TWE_IDLE,
      TWE_DEV,
      TWE_WADDR,
      TWE_WDATA,
      TWE_READ,
      TWE_IGNORE
   } twe_state_t;
endpackage

/* File: hdl/twe_sync2.sv */
// Two-flop level synchroniser
`timescale 1ns/10ps
`default_nettype none
module twe_sync2 #(
   parameter int W = 1
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // Asynchronous levels in, synchronised levels out
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);
   typedef struct packed {
      logic [W-1:0] s1;
      logic [W-1:0] s2;
   } twe_sync_st_t;

   twe_sync_st_t r;
   twe_sync_st_t next_r;

   always_comb begin
      next_r = r;
      next_r.s1 = d;
      next_r.s2 = r.s1;
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         r <= '0;
      end else begin
         r <= next_r;
      end
   end

   // Only the second stage leaves this module
   assign q = r.s2;
endmodule
`default_nettype wire

/* File: hdl/twe_buf2.sv */
// Two-entry valid/ready buffer for received write bytes
`timescale 1ns/10ps
`default_nettype none
module twe_buf2 (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // Fill side
   input wire logic in_valid,
   output logic in_ready,
   input wire twe_pkg::twe_wbyte_t in_data,
   // Drain side
   output logic out_valid,
   input wire logic out_ready,
   output twe_pkg::twe_wbyte_t out_data
);
   import twe_pkg::*;

   typedef struct packed {
      twe_wbyte_t [1:0] ent;
      logic [1:0] cnt;
      logic rd;
   } twe_buf_st_t;

   twe_buf_st_t r;
   twe_buf_st_t next_r;
   logic push;
   logic pop;

   assign in_ready = (r.cnt != 2'h2);
   assign out_valid = (r.cnt != 2'h0);
   assign out_data = r.ent[r.rd];
   assign push = in_valid & in_ready;
   assign pop = out_valid & out_ready;

   always_comb begin
      next_r = r;
      if (push) begin
         next_r.ent[r.rd ^ r.cnt[0]] = in_data;
      end
      if (pop) begin
         next_r.rd = ~r.rd;
      end
      case ({push, pop})
         2'b10: next_r.cnt = r.cnt + 2'h1;
         2'b01: next_r.cnt = r.cnt - 2'h1;
         default: next_r.cnt = r.cnt;
      endcase
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         r <= '0;
      end else begin
         r <= next_r;
      end
   end
endmodule
`default_nettype wire

/* File: dv/twe_target_props.sv */
// Concurrent checks on the two-wire memory target ports
`timescale 1ns/10ps
`default_nettype none
module twe_target_props #(
   parameter int unsigned write_cycles = twe_pkg::TWE_WRITE_CYCLES
) (
   // Clock and reset
   input wire logic ref_clk,
   input wire logic rst_n,
   // Serial link
   input wire logic scl_clk,
   input wire logic sda_i,
   input wire logic sda_o,
   input wire logic sda_oe,
   // Straps and status
   input wire twe_pkg::twe_straps_t straps,
   input wire logic write_busy
);
   import twe_pkg::*;
   int unsigned busy_len;
   // Counts busy cycles so the self-timed wait can be bounded
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         busy_len <= 0;
      end else begin
         busy_len <= write_busy ? busy_len + 1 : 0;
      end
   end
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!rst_n);
   sequence scl_rise;
      !scl_clk ##1 scl_clk;
   endsequence
   sequence bus_stop;
      scl_clk ##1 (scl_clk && $rose(sda_i));
   endsequence
   drive_low_only_a: assert property (sda_o == 1'b0)
      else $error("data output not low");
   oe_after_fall_a: assert property ($changed(sda_oe) |-> $fell(scl_clk))
      else $error("data enable moved off a clock fall");
   rise_stable_a: assert property (scl_rise |-> $stable(sda_oe) [*2])
      else $error("data enable moved in clock high");
   stop_released_a: assert property (bus_stop |-> !sda_oe)
      else $error("data held low at stop");
   busy_quiet_a: assert property (write_busy |-> !sda_oe)
      else $error("answer given while programming");
   busy_bound_a: assert property (write_busy |-> busy_len < write_cycles + 16)
      else $error("programming overran");
   busy_length_a: assert property ($fell(write_busy) |-> busy_len >= write_cycles)
      else $error("programming too short");
   protect_block_a: assert property ($rose(write_busy) |-> !straps.write_protect)
      else $error("programming under write protect");
endmodule
bind twe_target twe_target_props #(.write_cycles(write_cycles)) u_props (
   .ref_clk(ref_clk), .rst_n(rst_n), .scl_clk(scl_clk), .sda_i(sda_i),
   .sda_o(sda_o), .sda_oe(sda_oe), .straps(straps), .write_busy(write_busy)
);
`default_nettype wire

/* File: dv/twe_ctrl_model.sv */
// Behavioural two-wire bus controller driving the serial clock
`timescale 1ns/10ps
`default_nettype none
module twe_ctrl_model (
   // Serial link
   output logic scl,
   output logic pull_low,
   input wire logic sda
);
   initial begin
      scl = 1'b1; // Clock stands high between frames
      pull_low = 1'b0;
   end
   // Phases of ten reference cycles give the synchronised engine time to answer before the fall
   task automatic clk_bit(input logic b, output logic s);
      pull_low = !b; // Data moves only while the clock is low
      #50 scl = 1'b1;
      #90 s = sda;
      #10 scl = 1'b0;
      #50;
   endtask
   // Also serves as repeated start; long hold lets the synchroniser see it
   task automatic start_cond();
      pull_low = 1'b0;
      #50 scl = 1'b1;
      #100 pull_low = 1'b1;
      #100 scl = 1'b0;
      #50;
   endtask
   task automatic stop_cond();
      pull_low = 1'b1;
      #50 scl = 1'b1;
      #100 pull_low = 1'b0;
      #100;
   endtask
   task automatic xfer(input logic [7:0] tx, input logic ack_in, output logic [7:0] rx, output logic ack);
      logic s;
      for (int i = 7; i >= 0; i--) begin
         clk_bit(tx[i], s);
         rx[i] = s;
      end
      clk_bit(ack_in, s);
      ack = !s;
   endtask
endmodule
`default_nettype wire

/* File: dv/twe_target_tb.sv */
// Self-checking bench for the two-wire memory target
`timescale 1ns/10ps
`default_nettype none
module twe_target_tb;
   import twe_pkg::*;
   // Long enough that the polling probe after a write still falls inside the busy time
   localparam int unsigned WCYC = 400;
   logic ref_clk, rst_n, scl_clk, pull_low, sda_i, sda_o, sda_oe, write_busy;
   twe_straps_t straps;
   logic [7:0] mem [256];
   int num_errors = 0;
   int checks_done = 0;
   assign sda_i = !(sda_oe || pull_low); // Pull-up when nobody pulls low
   twe_target #(.large_array(1'b1), .write_cycles(WCYC)) uut (.ref_clk(ref_clk), .rst_n(rst_n),
      .scl_clk(scl_clk), .sda_i(sda_i), .sda_o(sda_o), .sda_oe(sda_oe), .straps(straps),
      .write_busy(write_busy));
   twe_ctrl_model ctrl (.scl(scl_clk), .pull_low(pull_low), .sda(sda_i));
   initial begin
      ref_clk = 1'b0;
      forever #5 ref_clk = !ref_clk;
   end
   task automatic end_of_test();
      if (num_errors == 0 && checks_done > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask
   task automatic check(input logic [7:0] got, input logic [7:0] exp);
      checks_done++;
      if (got !== exp) begin
         num_errors++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   function automatic logic [7:0] sel_byte(input logic [2:0] cs, input logic rd);
      return {TWE_TYPE_CODE, cs, rd};
   endfunction
   task automatic set_straps(input logic [2:0] cs, input logic wp);
      @(posedge ref_clk);
      straps <= {cs, wp};
      repeat (4) @(posedge ref_clk);
   endtask
   task automatic probe(input logic [2:0] cs, input logic exp);
      logic [7:0] rx;
      logic ack;
      ctrl.start_cond();
      ctrl.xfer(sel_byte(cs, 1'b0), 1'b1, rx, ack);
      ctrl.stop_cond();
      check(8'(ack), 8'(exp));
   endtask
   task automatic write_page(input logic [7:0] base, input int n);
      logic [7:0] rx, d;
      logic ack;
      ctrl.start_cond();
      ctrl.xfer(sel_byte(straps.chip_select, 1'b0), 1'b1, rx, ack);
      check(8'(ack), 8'h1);
      ctrl.xfer(base, 1'b1, rx, ack);
      for (int i = 0; i < n; i++) begin
         d = 8'($urandom);
         ctrl.xfer(d, 1'b1, rx, ack);
         check(8'(ack), 8'h1);
         if (!straps.write_protect) mem[{base[7:3], 3'(base[2:0] + i)}] = d;
      end
      ctrl.stop_cond();
   endtask
   task automatic read_seq(input logic [7:0] base, input int n);
      logic [7:0] rx;
      logic ack;
      ctrl.start_cond();
      ctrl.xfer(sel_byte(straps.chip_select, 1'b0), 1'b1, rx, ack);
      ctrl.xfer(base, 1'b1, rx, ack);
      ctrl.start_cond();
      ctrl.xfer(sel_byte(straps.chip_select, 1'b1), 1'b1, rx, ack);
      check(8'(ack), 8'h1);
      for (int i = 0; i < n; i++) begin
         ctrl.xfer(8'hff, (i == n - 1), rx, ack);
         check(rx, mem[8'(base + i)]);
      end
      ctrl.stop_cond();
   endtask
   task automatic settle(input logic exp_busy);
      int n;
      n = 0;
      @(negedge ref_clk);
      check(8'(write_busy), 8'(exp_busy));
      while (write_busy === 1'b1 && n < 500) begin
         @(negedge ref_clk);
         n++;
      end
      check(8'(write_busy), 8'h0);
   endtask
   initial begin
      #500_000;
      num_errors++;
      end_of_test();
   end
   initial begin
      logic [7:0] base;
      logic [4:0] page;
      void'($urandom(32'h288ae167));
      rst_n = 1'b0;
      straps = '0;
      repeat (12) @(posedge ref_clk);
      rst_n <= 1'b1;
      repeat (4) @(posedge ref_clk);
      for (int k = 0; k < 8; k++) begin
         set_straps(3'(k), 1'b0);
         probe(3'(k), 1'b1);
         probe(3'(k) ^ 3'(1 + $urandom % 7), 1'b0);
      end
      set_straps(3'($urandom), 1'b0);
      page = 5'($urandom);
      // Nine bytes roll over within the page and overwrite the first
      for (int r = 0; r < 4; r++) begin
         base = {page, 3'($urandom)};
         write_page(base, (r == 0) ? 8 : 1 + $urandom % 9);
         probe(straps.chip_select, 1'b0);
         settle(1'b1);
         read_seq({page, 3'h0}, 8);
      end
      set_straps(straps.chip_select, 1'b1);
      write_page(base, 4);
      settle(1'b0);
      read_seq({page, 3'h0}, 8);
      end_of_test();
   end
endmodule
`default_nettype wire
